// [agt_consts.svh]
// Offsets, field positions, reset values and timing figures of the
// auto gain / exposure / test pattern block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef AGT_CONSTS_SVH
`define AGT_CONSTS_SVH

`define AGT_ADDR_W 4
`define AGT_DATA_W 16
`define AGT_PIX_W 12
`define AGT_CNT_W 22

`define AGT_REG_FLAG 4'h0
`define AGT_REG_CONFIG 4'h1
`define AGT_REG_REF 4'h2
`define AGT_REG_MANUAL_GAIN 4'h3
`define AGT_REG_STATUS 4'h4
`define AGT_REG_EXPOSURE 4'h5
`define AGT_REG_PAGE_SAVE 4'h6
`define AGT_REG_PAGE_BASE 4'h8
`define AGT_PAGE_COUNT 6

`define AGT_FLAG_GAIN_BIT 15
`define AGT_FLAG_EXPO_BIT 14
`define AGT_CFG_PATTERN_BIT 0
`define AGT_CFG_WIDE_BIT 1
`define AGT_CFG_SHUT_LSB 2

`define AGT_FLAG_RESET 16'h0000
`define AGT_CONFIG_RESET 16'h0000
`define AGT_REF_RESET 16'h0200
`define AGT_MANUAL_RESET 16'h0000

`define AGT_GAIN_SPAN_DB 20
`define AGT_GAIN_STEPS_PER_DB 10
`define AGT_SHUTTER_MIN_NS 1000000
`define AGT_CLK_PERIOD_NS 20
`define AGT_PAT_SHIFT_NARROW 2
`define AGT_PAT_SHIFT_WIDE 4

`endif

// [agt_pkg.sv]
// Types shared by the auto gain / exposure / test pattern block.
// Assumes agt_consts.svh sits beside it.
`include "agt_consts.svh"

package agt_pkg;

  typedef enum logic [1:0] {
    AGT_MODE_OFF,
    AGT_MODE_EXPO,
    AGT_MODE_GAIN,
    AGT_MODE_BAD
  } agt_mode_type;

  typedef enum logic [1:0] {
    AGT_SHUT_NONE,
    AGT_SHUT_CONT,
    AGT_SHUT_ASYNC
  } agt_shutter_type;

  typedef struct packed {
    logic [`AGT_ADDR_W-1:0] addr;
    logic [`AGT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } agt_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [`AGT_PIX_W-1:0] data;
  } agt_pix_type;

  typedef struct packed {
    logic done;
    logic [`AGT_PIX_W+`AGT_CNT_W-1:0] sum;
    logic [`AGT_CNT_W-1:0] count;
  } agt_avg_type;

  function automatic agt_mode_type agt_decode_mode(input logic [`AGT_DATA_W-1:0] flag);
    agt_mode_type mode;
    mode = AGT_MODE_OFF;
    unique case ({flag[`AGT_FLAG_GAIN_BIT], flag[`AGT_FLAG_EXPO_BIT]})
      2'b00: mode = AGT_MODE_OFF;
      2'b01: mode = AGT_MODE_EXPO;
      2'b10: mode = AGT_MODE_GAIN;
      2'b11: mode = AGT_MODE_BAD;
    endcase
    return mode;
  endfunction

endpackage

// [agt_frame_avg.sv]
// Per-frame pixel sum and count, handed over on each frame start.
// Assumes frame_start_in and pixels come from logic on clk_in.
`timescale 1ns/10ps
`default_nettype none

module agt_frame_avg
  import agt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire agt_pix_type pix_in,
  input wire logic frame_start_in,
  output var agt_avg_type avg_out
);

  localparam int SUM_W = `AGT_PIX_W + `AGT_CNT_W;

  logic [SUM_W-1:0] sum;
  logic [`AGT_CNT_W-1:0] count;
  logic [SUM_W-1:0] next_sum;
  logic [`AGT_CNT_W-1:0] next_count;
  agt_avg_type next_avg;

  always_comb begin
    next_sum = sum;
    next_count = count;
    next_avg = avg_out;
    next_avg.done = 1'b0;
    if (frame_start_in) begin
      // Hand over the finished frame, restart accumulation
      next_avg.done = (count != '0);
      next_avg.sum = sum;
      next_avg.count = count;
      next_sum = '0;
      next_count = '0;
    end else if (pix_in.valid && count != '1) begin
      next_sum = sum + SUM_W'(pix_in.data);
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sum <= '0;
      count <= '0;
      avg_out <= '0;
    end else begin
      sum <= next_sum;
      count <= next_count;
      avg_out <= next_avg;
    end
  end

endmodule

`default_nettype wire

// [agt_pattern.sv]
// Horizontal sawtooth test pattern, one step per valid pixel.
// Assumes pix_valid_in marks each horizontal pixel on clk_in.
`timescale 1ns/10ps
`default_nettype none

module agt_pattern
  import agt_pkg::*;
#(
  parameter int STEP_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pix_valid_in,
  input wire logic wide_in,
  output logic [`AGT_PIX_W-1:0] pattern_out
);

  logic [STEP_W-1:0] phase;
  logic [STEP_W-1:0] next_phase;

  // Free running, so active area may start at any value
  always_comb begin
    next_phase = phase;
    if (pix_valid_in) begin
      next_phase = phase + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  // Low bits held at zero: steps of 4 up to 1020, or 16 up to 4080
  always_comb begin
    if (wide_in) begin
      pattern_out = `AGT_PIX_W'(phase) << `AGT_PAT_SHIFT_WIDE;
    end else begin
      pattern_out = `AGT_PIX_W'(phase) << `AGT_PAT_SHIFT_NARROW;
    end
  end

  chk_phase_step: assert property (@(posedge clk_in) disable iff (rst_in)
    pix_valid_in |=> phase == STEP_W'($past(phase) + 1'b1))
    else $error("Pattern phase did not advance by one step");

endmodule

`default_nettype wire

// [agt_top.sv]
// Auto gain loop, auto exposure loop and test pattern insertion, with
// their register file.
// Assumes pixels, frame start and register strobes come from logic on
// clk_in; sensor_pix_in has already passed gain and offset processing.
//
// Behaviour
// - Gain loop nudges amplifier gain until frame average equals reference.
// - Loop gain spans about 20 dB of amplifier range.
// - Flag bits 15,14: 00 off at reset, 01 exposure, 10 gain.
// - Exposure loop nudges shutter time until average equals same reference.
// - Auto exposure runs continuous shutter, steps one line, 1 ms to frame.
// - Auto exposure forces continuous shutter even when no-shutter is chosen.
// - Without auto gain the manual gain setting drives the amplifier.
// - Page-save commands store the flag register per program page.
// - Test pattern replaces sensor pixels while enabled.
// - Ten-bit pattern rises by 4 per pixel and wraps after 1020.
// - Pattern low two bits zero; twelve-bit mode spans 0 to 4080.
// - Sawtooth phase is not aligned to the active area start.
// - Pattern bypasses gain and offset processing.
// - Pattern enable resets off and is written through the config register.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module agt_top
  import agt_pkg::*;
#(
  parameter int FRAME_LINES = 1040,
  parameter int LINE_CYCLES = 1600,
  parameter int EXP_W = 11
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire agt_reg_req_type reg_req_in,
  output var logic [`AGT_DATA_W-1:0] reg_rdata_out,
  input wire agt_pix_type sensor_pix_in,
  input wire logic frame_start_in,
  output var agt_pix_type video_pix_out,
  output var logic [7:0] amp_gain_out,
  output var logic [EXP_W-1:0] exposure_lines_out,
  output var agt_shutter_type shutter_mode_out
);

  localparam int DW = `AGT_DATA_W;
  localparam int SUM_W = `AGT_PIX_W + `AGT_CNT_W;
  localparam logic [7:0] GAIN_MAX = 8'(`AGT_GAIN_SPAN_DB * `AGT_GAIN_STEPS_PER_DB);
  localparam int MIN_CYCLES = `AGT_SHUTTER_MIN_NS / `AGT_CLK_PERIOD_NS;
  localparam logic [EXP_W-1:0] EXP_MIN = EXP_W'((MIN_CYCLES + LINE_CYCLES - 1) / LINE_CYCLES);
  localparam logic [EXP_W-1:0] EXP_MAX = EXP_W'(FRAME_LINES);

  // Register file
  logic [DW-1:0] flag_register;
  logic [DW-1:0] config_reg;
  logic [DW-1:0] ref_level;
  logic [DW-1:0] manual_gain_setting;
  logic [DW-1:0] page_store [`AGT_PAGE_COUNT];
  logic [DW-1:0] next_flag_register;
  logic [DW-1:0] next_config_reg;
  logic [DW-1:0] next_ref_level;
  logic [DW-1:0] next_manual_gain_setting;
  logic [DW-1:0] next_page_store [`AGT_PAGE_COUNT];
  logic [DW-1:0] next_rdata;

  // Loops and outputs
  logic [7:0] gain_loop;
  logic [EXP_W-1:0] exposure_loop;
  logic [7:0] next_gain_loop;
  logic [EXP_W-1:0] next_exposure_loop;
  logic [7:0] next_amp_gain;
  agt_shutter_type next_shutter;
  agt_shutter_type cfg_shutter;
  agt_pix_type next_video;

  agt_mode_type mode;
  agt_avg_type frame_avg;
  logic [SUM_W:0] low_bound;
  logic [SUM_W:0] high_bound;
  logic too_bright;
  logic too_dark;
  logic [`AGT_PIX_W-1:0] pattern;
  logic pattern_on;
  logic wide_out;
  logic page_save;
  logic [2:0] page_idx;

  assign mode = agt_decode_mode(flag_register);
  assign pattern_on = config_reg[`AGT_CFG_PATTERN_BIT];
  assign wide_out = config_reg[`AGT_CFG_WIDE_BIT];
  assign page_idx = reg_req_in.wdata[2:0];
  assign page_save = reg_req_in.wr && reg_req_in.addr == `AGT_REG_PAGE_SAVE;

  agt_frame_avg u_avg (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pix_in(sensor_pix_in),
    .frame_start_in(frame_start_in),
    .avg_out(frame_avg)
  );

  agt_pattern #(
    .STEP_W(8)
  ) u_pattern (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pix_valid_in(sensor_pix_in.valid),
    .wide_in(wide_out),
    .pattern_out(pattern)
  );

  // Average equals reference when ref*n <= sum < (ref+1)*n; no divider
  always_comb begin
    low_bound = (SUM_W+1)'(ref_level[`AGT_PIX_W-1:0] * frame_avg.count);
    high_bound = low_bound + (SUM_W+1)'(frame_avg.count);
    too_dark = (SUM_W+1)'(frame_avg.sum) < low_bound;
    too_bright = (SUM_W+1)'(frame_avg.sum) >= high_bound;
  end

  always_comb begin
    unique case (config_reg[`AGT_CFG_SHUT_LSB +: 2])
      2'b01: cfg_shutter = AGT_SHUT_CONT;
      2'b10: cfg_shutter = AGT_SHUT_ASYNC;
      default: cfg_shutter = AGT_SHUT_NONE;
    endcase
  end

  // Register writes, page saves and read data
  always_comb begin
    next_flag_register = flag_register;
    next_config_reg = config_reg;
    next_ref_level = ref_level;
    next_manual_gain_setting = manual_gain_setting;
    next_page_store = page_store;
    next_rdata = '0;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        `AGT_REG_FLAG: next_flag_register = reg_req_in.wdata;
        `AGT_REG_CONFIG: next_config_reg = reg_req_in.wdata;
        `AGT_REG_REF: next_ref_level = reg_req_in.wdata;
        `AGT_REG_MANUAL_GAIN: next_manual_gain_setting = reg_req_in.wdata;
        default: ;
      endcase
    end
    if (page_save && page_idx < 3'(`AGT_PAGE_COUNT)) begin
      next_page_store[page_idx] = flag_register;
    end
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        `AGT_REG_FLAG: next_rdata = flag_register;
        `AGT_REG_CONFIG: next_rdata = config_reg;
        `AGT_REG_REF: next_rdata = ref_level;
        `AGT_REG_MANUAL_GAIN: next_rdata = manual_gain_setting;
        `AGT_REG_STATUS: next_rdata = {amp_gain_out, 4'h0, shutter_mode_out, mode};
        `AGT_REG_EXPOSURE: next_rdata = DW'(exposure_lines_out);
        default: begin
          if (reg_req_in.addr >= `AGT_REG_PAGE_BASE
              && reg_req_in.addr < `AGT_REG_PAGE_BASE + 4'(`AGT_PAGE_COUNT)) begin
            next_rdata = page_store[3'(reg_req_in.addr - `AGT_REG_PAGE_BASE)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_register <= `AGT_FLAG_RESET;
      config_reg <= `AGT_CONFIG_RESET;
      ref_level <= `AGT_REF_RESET;
      manual_gain_setting <= `AGT_MANUAL_RESET;
      for (int i = 0; i < `AGT_PAGE_COUNT; i++) begin
        page_store[i] <= `AGT_FLAG_RESET;
      end
      reg_rdata_out <= '0;
    end else begin
      flag_register <= next_flag_register;
      config_reg <= next_config_reg;
      ref_level <= next_ref_level;
      manual_gain_setting <= next_manual_gain_setting;
      page_store <= next_page_store;
      reg_rdata_out <= next_rdata;
    end
  end

  // Control loops: one step per finished frame; both-bits-set runs neither
  always_comb begin
    next_gain_loop = gain_loop;
    next_exposure_loop = exposure_loop;
    if (mode != AGT_MODE_GAIN) begin
      // Track manual gain so switching the loop on starts without a jump
      next_gain_loop = (manual_gain_setting[7:0] > GAIN_MAX) ? GAIN_MAX : manual_gain_setting[7:0];
    end else if (frame_avg.done) begin
      if (too_dark && gain_loop < GAIN_MAX) begin
        next_gain_loop = gain_loop + 1'b1;
      end else if (too_bright && gain_loop != '0) begin
        next_gain_loop = gain_loop - 1'b1;
      end
    end
    if (mode != AGT_MODE_EXPO) begin
      next_exposure_loop = EXP_MAX;
    end else if (frame_avg.done) begin
      if (too_dark && exposure_loop < EXP_MAX) begin
        next_exposure_loop = exposure_loop + 1'b1;
      end else if (too_bright && exposure_loop > EXP_MIN) begin
        next_exposure_loop = exposure_loop - 1'b1;
      end
    end
    next_amp_gain = (mode == AGT_MODE_GAIN) ? gain_loop : manual_gain_setting[7:0];
    next_shutter = (mode == AGT_MODE_EXPO) ? AGT_SHUT_CONT : cfg_shutter;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gain_loop <= '0;
      exposure_loop <= EXP_MAX;
      amp_gain_out <= '0;
      exposure_lines_out <= EXP_MAX;
      shutter_mode_out <= AGT_SHUT_NONE;
    end else begin
      gain_loop <= next_gain_loop;
      exposure_loop <= next_exposure_loop;
      amp_gain_out <= next_amp_gain;
      exposure_lines_out <= exposure_loop;
      shutter_mode_out <= next_shutter;
    end
  end

  // Pattern is inserted after gain and offset, so neither touches it
  always_comb begin
    next_video = sensor_pix_in;
    if (pattern_on) begin
      next_video.data = pattern;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      video_pix_out <= '0;
    end else begin
      video_pix_out <= next_video;
    end
  end

  chk_gain_rises: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode == AGT_MODE_GAIN && frame_avg.done && too_dark && gain_loop < GAIN_MAX)
    |=> gain_loop == 8'($past(gain_loop) + 1'b1))
    else $error("Gain loop did not rise on a dark frame");

  chk_gain_span: assert property (@(posedge clk_in) disable iff (rst_in)
    gain_loop <= GAIN_MAX)
    else $error("Gain loop left its span");

  chk_mode_gain: assert property (@(posedge clk_in) disable iff (rst_in)
    (flag_register[15:14] == 2'b10) |=> amp_gain_out == $past(gain_loop))
    else $error("Flag 10 did not select the gain loop");

  chk_exp_falls: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode == AGT_MODE_EXPO && frame_avg.done && too_bright && exposure_loop > EXP_MIN)
    |=> exposure_loop == EXP_W'($past(exposure_loop) - 1'b1))
    else $error("Exposure did not shorten on a bright frame");

  chk_exp_range: assert property (@(posedge clk_in) disable iff (rst_in)
    exposure_loop >= EXP_MIN && exposure_loop <= EXP_MAX)
    else $error("Exposure left its line range");

  chk_shutter_cont: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode == AGT_MODE_EXPO) |=> shutter_mode_out == AGT_SHUT_CONT)
    else $error("Auto exposure without continuous shutter");

  chk_manual_gain: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode != AGT_MODE_GAIN) |=> amp_gain_out == $past(manual_gain_setting[7:0]))
    else $error("Manual gain not applied");

  chk_page_save: assert property (@(posedge clk_in) disable iff (rst_in)
    (page_save && page_idx < 3'(`AGT_PAGE_COUNT))
    |=> page_store[$past(page_idx)] == $past(flag_register))
    else $error("Page did not store the flag register");

  chk_pattern_out: assert property (@(posedge clk_in) disable iff (rst_in)
    (pattern_on && sensor_pix_in.valid) |=> video_pix_out.valid && video_pix_out.data == $past(pattern))
    else $error("Pattern not on the output");

  chk_pattern_lsb: assert property (@(posedge clk_in) disable iff (rst_in)
    (pattern_on && !wide_out) |=> video_pix_out.data[1:0] == 2'b00 && video_pix_out.data[11:10] == 2'b00)
    else $error("Narrow pattern bits out of range");

  chk_once_frame: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode == AGT_MODE_GAIN && $past(mode) == AGT_MODE_GAIN && !$past(frame_avg.done)) |-> $stable(gain_loop))
    else $error("Gain loop moved mid frame");

  cov_gain_step: cover property (@(posedge clk_in) disable iff (rst_in)
    mode == AGT_MODE_GAIN && frame_avg.done && too_bright && gain_loop != '0);
  cov_exp_step: cover property (@(posedge clk_in) disable iff (rst_in)
    mode == AGT_MODE_EXPO && frame_avg.done && too_dark && exposure_loop < EXP_MAX);
  cov_pattern: cover property (@(posedge clk_in) disable iff (rst_in)
    pattern_on && wide_out && sensor_pix_in.valid);

endmodule

`default_nettype wire

// [agt_host_model.sv]
// Host software model issuing register writes and reads on the plain port.
// Assumes the testbench calls its tasks and owns clk_in.
`timescale 1ns/10ps
`default_nettype none

module agt_host_model
  import agt_pkg::*;
(
  input wire logic clk_in,
  input wire logic [`AGT_DATA_W-1:0] rdata_in,
  output var agt_reg_req_type req_out
);
  initial begin
    req_out = '0;
  end

  task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    // Software never enables both loops; gain bit dropped
    if (addr == `AGT_REG_FLAG && d[15] && d[14]) begin
      d[15] = 1'b0;
    end
    @(posedge clk_in);
    req_out <= '{addr: addr, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req_out.wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] addr, output logic [15:0] data);
    @(posedge clk_in);
    req_out <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req_out.rd <= 1'b0;
    #1;
    data = rdata_in;
  endtask
endmodule

`default_nettype wire

// [agt_tb.sv]
// Self-checking bench for agt_top: registers, both loops, test pattern.
// Assumes agt_host_model drives the register port; bench drives pixels.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench
  import agt_pkg::*;
;
  localparam int FL = 40;
  localparam int LC = 1600;
  // Shortest exposure in whole lines, rounded up
  localparam int EXP_MIN = (`AGT_SHUTTER_MIN_NS + LC * `AGT_CLK_PERIOD_NS - 1) / (LC * `AGT_CLK_PERIOD_NS);
  logic clk_in;
  logic rst_in;
  logic frame_start;
  agt_pix_type sensor_pix;
  agt_pix_type video_pix;
  agt_reg_req_type reg_req;
  logic [15:0] rdata;
  logic [7:0] amp;
  logic [10:0] expo;
  agt_shutter_type shut;
  int failures;
  int samples_checked;

  agt_host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .req_out(reg_req));

  agt_top #(.FRAME_LINES(FL), .LINE_CYCLES(LC), .EXP_W(11)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req), .reg_rdata_out(rdata),
    .sensor_pix_in(sensor_pix), .frame_start_in(frame_start), .video_pix_out(video_pix),
    .amp_gain_out(amp), .exposure_lines_out(expo), .shutter_mode_out(shut));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic t_reset;
    logic [15:0] d;
    logic [15:0] exp_val [5];
    exp_val = '{`AGT_FLAG_RESET, `AGT_CONFIG_RESET, `AGT_REF_RESET, `AGT_MANUAL_RESET, 16'h0000};
    rst_in <= 1'b1;
    tick(16);
    rst_in <= 1'b0;
    tick(1);
    `CHK("amp_gain", 8'h00, amp)
    `CHK("exposure", 11'(FL), expo)
    `CHK("shutter", AGT_SHUT_NONE, shut)
    `CHK("rdata_idle", 16'h0000, rdata)
    for (int a = 0; a < 5; a++) begin
      i_host.reg_read((a == 4) ? 4'h7 : 4'(a), d);
      `CHK("reset_reg", exp_val[a], d)
    end
    $display("test reset done");
  endtask

  task automatic t_modes;
    logic [15:0] d;
    for (int m = 0; m < 3; m++) begin
      i_host.reg_write(`AGT_REG_FLAG, {m[1], m[0], 14'h0000});
      i_host.reg_read(`AGT_REG_STATUS, d);
      `CHK("mode", 2'(m), d[1:0])
    end
    i_host.reg_write(`AGT_REG_FLAG, 16'h0000);
    $display("test modes done");
  endtask

  task automatic frame(input logic [11:0] lvl);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      sensor_pix <= '{valid: 1'b1, data: lvl};
    end
    @(posedge clk_in);
    sensor_pix.valid <= 1'b0;
    frame_start <= 1'b1;
    @(posedge clk_in);
    frame_start <= 1'b0;
    tick(5);
  endtask

  task automatic gain_run(input logic [7:0] man, input logic [11:0] lvl, input int dir);
    int g;
    i_host.reg_write(`AGT_REG_FLAG, 16'h0000);
    i_host.reg_write(`AGT_REG_MANUAL_GAIN, {8'h00, man});
    i_host.reg_write(`AGT_REG_REF, 16'h0064);
    // Flush stale pixels while the loop only tracks manual gain
    frame(lvl);
    `CHK("manual_gain", man, amp)
    i_host.reg_write(`AGT_REG_FLAG, 16'h8000);
    g = man;
    for (int k = 0; k < 4; k++) begin
      frame(lvl);
      g = g + dir;
      g = (g < 0) ? 0 : (g > 200) ? 200 : g;
      `CHK("gain_step", 8'(g), amp)
      tick(20);
      `CHK("gain_hold", 8'(g), amp)
    end
    $display("test gain done");
  endtask

  task automatic t_expo;
    logic [15:0] d;
    int e;
    i_host.reg_write(`AGT_REG_FLAG, 16'h0000);
    i_host.reg_write(`AGT_REG_CONFIG, 16'h0000);
    i_host.reg_write(`AGT_REG_MANUAL_GAIN, 16'h0022);
    frame(12'h0C8);
    i_host.reg_write(`AGT_REG_FLAG, 16'h4000);
    tick(3);
    `CHK("shutter_cont", AGT_SHUT_CONT, shut)
    e = FL;
    for (int k = 0; k < 10; k++) begin
      frame(12'h0C8);
      e = (e > EXP_MIN) ? e - 1 : e;
      `CHK("expo_step", 11'(e), expo)
    end
    frame(12'h032);
    `CHK("expo_up", 11'(EXP_MIN + 1), expo)
    i_host.reg_read(`AGT_REG_EXPOSURE, d);
    `CHK("expo_reg", 16'(EXP_MIN + 1), d)
    `CHK("manual_in_expo", 8'h22, amp)
    i_host.reg_write(`AGT_REG_FLAG, 16'h0000);
    tick(3);
    `CHK("expo_off", 11'(FL), expo)
    `CHK("shutter_none", AGT_SHUT_NONE, shut)
    // Manual shutter field without auto exposure passes straight through
    i_host.reg_write(`AGT_REG_CONFIG, 16'h0008);
    tick(3);
    `CHK("shutter_async", AGT_SHUT_ASYNC, shut)
    i_host.reg_write(`AGT_REG_CONFIG, 16'h0004);
    tick(3);
    `CHK("shutter_cfg_cont", AGT_SHUT_CONT, shut)
    i_host.reg_write(`AGT_REG_CONFIG, 16'h0000);
    $display("test exposure done");
  endtask

  task automatic pattern_run(input logic [15:0] cfg, input logic [11:0] step, input logic [11:0] lim);
    logic [11:0] prev;
    logic [11:0] pd;
    logic pv;
    logic have;
    i_host.reg_write(`AGT_REG_CONFIG, cfg);
    have = 1'b0;
    pv = 1'b0;
    pd = 12'h000;
    // Idle slot every fifth cycle; the first value is not assumed zero
    for (int i = 0; i < 340; i++) begin
      @(posedge clk_in);
      sensor_pix <= '{valid: (i % 5 != 4), data: 12'(i * 7)};
      #1;
      if (i > 0) `CHK("video_valid", pv, video_pix.valid)
      if (i > 0 && pv && cfg[0]) begin
        if (have) `CHK("pattern_step", (prev + step) & lim, video_pix.data)
        `CHK("pattern_low", 12'h000, video_pix.data & ((step - 12'h001) | ~lim))
        prev = video_pix.data;
        have = 1'b1;
      end else if (i > 0 && pv) begin
        `CHK("passthru", pd, video_pix.data)
      end
      pv = (i % 5 != 4);
      pd = 12'(i * 7);
    end
    @(posedge clk_in);
    sensor_pix.valid <= 1'b0;
    $display("test pattern done");
  endtask

  task automatic t_pages;
    logic [15:0] d;
    for (int p = 0; p < 6; p++) begin
      i_host.reg_write(`AGT_REG_FLAG, 16'h0100 + 16'(p));
      i_host.reg_write(`AGT_REG_PAGE_SAVE, 16'(p));
    end
    i_host.reg_write(`AGT_REG_FLAG, 16'h00FF);
    i_host.reg_write(`AGT_REG_PAGE_SAVE, 16'h0006);
    i_host.reg_write(`AGT_REG_PAGE_BASE + 4'h1, 16'h0F0F);
    for (int p = 0; p < 6; p++) begin
      i_host.reg_read(`AGT_REG_PAGE_BASE + 4'(p), d);
      `CHK("page", 16'h0100 + 16'(p), d)
    end
    i_host.reg_read(`AGT_REG_FLAG, d);
    `CHK("flag_kept", 16'h00FF, d)
    // Pattern left on so the second reset shows it clears
    i_host.reg_write(`AGT_REG_CONFIG, 16'h0001);
    $display("test pages done");
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    summarize;
  end

  initial begin
    rst_in = 1'b1;
    frame_start = 1'b0;
    sensor_pix = '0;
    failures = 0;
    samples_checked = 0;
    t_reset;
    t_modes;
    gain_run(8'h05, 12'h032, 1);
    gain_run(8'h02, 12'h0C8, -1);
    gain_run(8'hC6, 12'h032, 1);
    gain_run(8'h10, 12'h064, 0);
    t_expo;
    pattern_run(16'h0001, 12'h004, 12'h3FF);
    pattern_run(16'h0003, 12'h010, 12'hFFF);
    pattern_run(16'h0000, 12'h004, 12'h3FF);
    t_pages;
    t_reset;
    summarize;
  end
endmodule

`default_nettype wire
